// *** sdcmd_regs.svh ***
// constants of the command and clock-enable decoder
`ifndef SDCMD_REGS_SVH
`define SDCMD_REGS_SVH

// ----------------------------------------------------------------------
// address organisation defaults
// ----------------------------------------------------------------------
`define SDCMD_BA_W      3
`define SDCMD_A_W       15
`define SDCMD_MR_SEL_W  2

// ----------------------------------------------------------------------
// address bit positions
// ----------------------------------------------------------------------
`define SDCMD_A10       10
`define SDCMD_A12       12

// ----------------------------------------------------------------------
// ras/cas/we patterns with cs low
// ----------------------------------------------------------------------
`define SDCMD_RCW_MRS   3'h0
`define SDCMD_RCW_REF   3'h1
`define SDCMD_RCW_PRE   3'h2
`define SDCMD_RCW_ACT   3'h3
`define SDCMD_RCW_WR    3'h4
`define SDCMD_RCW_RD    3'h5
`define SDCMD_RCW_ZQ    3'h6
`define SDCMD_RCW_NOP   3'h7

// ----------------------------------------------------------------------
// timing counts in clock cycles
// ----------------------------------------------------------------------
`define SDCMD_CNT_W     8
`define SDCMD_BL8_CYC   8'h04
`define SDCMD_BC4_CYC   8'h02
`define SDCMD_TRP_CYC   8'h0B
`define SDCMD_TRFC_CYC  8'h40
`define SDCMD_TXP_CYC   8'h03

`endif

// *** sdcmd_pkg.sv ***
// types shared by the command and clock-enable decoder
`include "sdcmd_regs.svh"
package sdcmd_pkg;
	// decoded command classes
	typedef enum logic [3:0] {
		cmd_des = 4'b0000,
		cmd_nop = 4'b0001,
		cmd_mrs = 4'b0010,
		cmd_ref = 4'b0011,
		cmd_pre = 4'b0100,
		cmd_act = 4'b0101,
		cmd_wr  = 4'b0110,
		cmd_rd  = 4'b0111,
		cmd_zq  = 4'b1000
	} sdcmd_cmd_e;

	// power states of the device
	typedef enum logic [2:0] {
		pst_normal = 3'b000,
		pst_act_pd = 3'b001,
		pst_pre_pd = 3'b010,
		pst_pd     = 3'b011,
		pst_self   = 3'b100
	} sdcmd_pstate_e;

	// control pins sampled each rising edge
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic odt;
	} sdcmd_pins_s;

	// registered decode result
	typedef struct packed {
		logic       valid;
		sdcmd_cmd_e cmd;
		logic       auto_close;
		logic       chop4;
		logic       zq_long;
		logic       pre_all;
	} sdcmd_dec_s;
endpackage : sdcmd_pkg

// *** sdcmd_rcw_decode.sv ***
// ras/cas/we pattern to command class
`timescale 1ns/100ps
`default_nettype none
`include "sdcmd_regs.svh"
module sdcmd_rcw_decode (
	// command strobes
	input  wire logic              cs_n,
	input  wire logic              ras_n,
	input  wire logic              cas_n,
	input  wire logic              we_n,
	// class
	output sdcmd_pkg::sdcmd_cmd_e  cmd
);
	wire [2:0] rcw = {ras_n, cas_n, we_n};

	// deselect overrides every other strobe
	assign cmd = cs_n                   ? sdcmd_pkg::cmd_des :
	             (rcw == `SDCMD_RCW_MRS) ? sdcmd_pkg::cmd_mrs :
	             (rcw == `SDCMD_RCW_REF) ? sdcmd_pkg::cmd_ref :
	             (rcw == `SDCMD_RCW_PRE) ? sdcmd_pkg::cmd_pre :
	             (rcw == `SDCMD_RCW_ACT) ? sdcmd_pkg::cmd_act :
	             (rcw == `SDCMD_RCW_WR)  ? sdcmd_pkg::cmd_wr  :
	             (rcw == `SDCMD_RCW_RD)  ? sdcmd_pkg::cmd_rd  :
	             (rcw == `SDCMD_RCW_ZQ)  ? sdcmd_pkg::cmd_zq  :
	                                       sdcmd_pkg::cmd_nop;
endmodule : sdcmd_rcw_decode
`default_nettype wire

// *** sdcmd_bank_track.sv ***
// open-row tracking for every bank
`timescale 1ns/100ps
`default_nettype none
module sdcmd_bank_track #(
	parameter int BA_W = 3
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// bank events
	input  wire logic              open_ev,
	input  wire logic              close_ev,
	input  wire logic              close_all,
	input  wire logic [BA_W-1:0]   bank,
	// state
	output logic [(1<<BA_W)-1:0]   open_reg
);
	genvar g;
	// one flop per bank; close-all ignores the bank address
	generate
		for (g = 0; g < (1 << BA_W); g++) begin : g_bank
			wire hit = (bank == BA_W'(g));
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					open_reg[g] <= 1'b0;
				end else if (close_all | (close_ev & hit)) begin
					open_reg[g] <= 1'b0;
				end else if (open_ev & hit) begin
					open_reg[g] <= 1'b1;
				end
			end
		end
	endgenerate
endmodule : sdcmd_bank_track
`default_nettype wire

// *** sdcmd_decoder.sv ***
// command and clock-enable decoder top
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/100ps
`default_nettype none
`include "sdcmd_regs.svh"
module sdcmd_decoder #(
	parameter int BA_W = `SDCMD_BA_W,
	parameter int A_W  = `SDCMD_A_W
) (
	// clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// command pins
	input  wire sdcmd_pkg::sdcmd_pins_s pins,
	input  wire logic [BA_W-1:0]        ba,
	input  wire logic [A_W-1:0]         addr,
	// burst selection by a12 allowed
	input  wire logic                   otf_en,
	// decoded command
	output sdcmd_pkg::sdcmd_dec_s       dec_reg,
	output logic [BA_W-1:0]             bank_reg,
	output logic [A_W-1:0]              addr_reg,
	// mode register write
	output logic                        mr_write_reg,
	output logic [`SDCMD_MR_SEL_W-1:0]  mr_sel_reg,
	output logic [A_W-1:0]              mr_op_reg,
	// calibration kind
	output logic                        zq_init_reg,
	// power and status
	output sdcmd_pkg::sdcmd_pstate_e    pstate_reg,
	output logic                        refresh_en_reg,
	output logic                        busy_reg,
	output logic                        idle_reg,
	output logic [(1<<BA_W)-1:0]        open_reg
);
	// ------------------------------------------------------------------
	// sampled pins and command class
	// ------------------------------------------------------------------
	sdcmd_pkg::sdcmd_cmd_e cmd_raw;
	logic                  cke_prev_reg;
	logic                  zq_done_reg;
	logic [7:0]            burst_cnt_reg;
	logic [7:0]            prech_cnt_reg;
	logic [7:0]            ref_cnt_reg;
	logic [7:0]            exit_cnt_reg;
	logic [7:0]            burst_len;
	sdcmd_pkg::sdcmd_pstate_e state_next;
	sdcmd_pkg::sdcmd_pstate_e pd_kind;

	// odt is not wired into the decoder on purpose
	sdcmd_rcw_decode u_rcw (
		.cs_n  (pins.cs_n),
		.ras_n (pins.ras_n),
		.cas_n (pins.cas_n),
		.we_n  (pins.we_n),
		.cmd   (cmd_raw)
	);

	// ------------------------------------------------------------------
	// command qualification
	// ------------------------------------------------------------------
	// commands count only with cke high on both edges in normal state
	wire cke_hold = cke_prev_reg & pins.cke;
	wire in_norm  = (pstate_reg == sdcmd_pkg::pst_normal);
	wire sel      = cke_hold & in_norm & ~pins.cs_n;
	wire nop_des  = pins.cs_n | (cmd_raw == sdcmd_pkg::cmd_nop);
	wire take     = sel & ~nop_des;
	wire is_rd    = take & (cmd_raw == sdcmd_pkg::cmd_rd);
	wire is_wr    = take & (cmd_raw == sdcmd_pkg::cmd_wr);
	wire is_rw    = is_rd | is_wr;
	wire is_mrs   = take & (cmd_raw == sdcmd_pkg::cmd_mrs);
	wire is_ref   = take & (cmd_raw == sdcmd_pkg::cmd_ref);
	wire is_pre   = take & (cmd_raw == sdcmd_pkg::cmd_pre);
	wire is_act   = take & (cmd_raw == sdcmd_pkg::cmd_act);
	wire is_zq    = take & (cmd_raw == sdcmd_pkg::cmd_zq);
	wire a10      = addr[`SDCMD_A10];
	// without on-the-fly selection the burst is always eight (BL8)
	wire chop4    = otf_en & ~addr[`SDCMD_A12];
	wire zq_long  = is_zq & a10;
	wire auto_cl  = is_rw & a10;
	wire pre_all  = is_pre & a10;

	// ------------------------------------------------------------------
	// activity timers
	// ------------------------------------------------------------------
	assign burst_len = chop4 ? `SDCMD_BC4_CYC : `SDCMD_BL8_CYC;
	wire burst_busy = (burst_cnt_reg != 8'h00);
	wire prech_busy = (prech_cnt_reg != 8'h00);
	wire ref_busy   = (ref_cnt_reg != 8'h00);
	wire exit_busy  = (exit_cnt_reg != 8'h00);
	wire no_open    = (open_reg == '0);
	wire all_idle   = no_open & ~burst_busy & ~prech_busy & ~ref_busy & ~exit_busy;

	// ------------------------------------------------------------------
	// cke transitions against the state before this edge
	// ------------------------------------------------------------------
	wire cke_fall = cke_prev_reg & ~pins.cke;
	wire cke_rise = ~cke_prev_reg & pins.cke;
	wire sre_go   = in_norm & cke_fall & ~pins.cs_n & (cmd_raw == sdcmd_pkg::cmd_ref) & all_idle;
	wire pde_go   = in_norm & cke_fall & nop_des;
	wire exit_go  = ~in_norm & cke_rise & nop_des;

	// open banks win, then data or precharge work, then idle/refresh
	assign pd_kind = ~no_open ? sdcmd_pkg::pst_act_pd :
	                 (burst_busy | prech_busy) ? sdcmd_pkg::pst_pd :
	                 sdcmd_pkg::pst_pre_pd;

	// next power state
	always_comb begin
		state_next = pstate_reg;
		case (pstate_reg)
			sdcmd_pkg::pst_normal: begin
				if (sre_go) begin
					state_next = sdcmd_pkg::pst_self;
				end else if (pde_go) begin
					state_next = pd_kind;
				end
			end
			sdcmd_pkg::pst_act_pd,
			sdcmd_pkg::pst_pre_pd,
			sdcmd_pkg::pst_pd,
			sdcmd_pkg::pst_self: begin
				// cke low holds; only a rising cke with a nop or deselect exits
				if (exit_go) begin
					state_next = sdcmd_pkg::pst_normal;
				end
			end
			default: begin
				state_next = sdcmd_pkg::pst_normal;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// bank tracking
	// ------------------------------------------------------------------
	sdcmd_bank_track #(
		.BA_W (BA_W)
	) u_banks (
		.clk       (clk),
		.rst_n     (rst_n),
		.open_ev   (is_act),
		.close_ev  (is_pre | auto_cl),
		.close_all (pre_all),
		.bank      (ba),
		.open_reg  (open_reg)
	);

	// ------------------------------------------------------------------
	// state, cke history and timers
	// ------------------------------------------------------------------
	// reset pin acts only asynchronously
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pstate_reg   <= sdcmd_pkg::pst_normal;
			cke_prev_reg <= 1'b0;
		end else begin
			pstate_reg   <= state_next;
			cke_prev_reg <= pins.cke;
		end
	end

	// burst counter: only a new read or write can reload it before it runs out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			burst_cnt_reg <= 8'h00;
		end else if (is_rw) begin
			burst_cnt_reg <= burst_len;
		end else if (burst_busy) begin
			burst_cnt_reg <= burst_cnt_reg - 8'h01;
		end
	end

	// precharge timer; auto close waits for the burst to end first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prech_cnt_reg <= 8'h00;
		end else if (auto_cl) begin
			prech_cnt_reg <= 8'(burst_len + `SDCMD_TRP_CYC);
		end else if (is_pre) begin
			prech_cnt_reg <= `SDCMD_TRP_CYC;
		end else if (prech_busy) begin
			prech_cnt_reg <= prech_cnt_reg - 8'h01;
		end
	end

	// refresh and power-down exit timers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_cnt_reg  <= 8'h00;
			exit_cnt_reg <= 8'h00;
		end else begin
			ref_cnt_reg  <= is_ref ? `SDCMD_TRFC_CYC : (ref_busy ? ref_cnt_reg - 8'h01 : 8'h00);
			exit_cnt_reg <= exit_go ? `SDCMD_TXP_CYC : (exit_busy ? exit_cnt_reg - 8'h01 : 8'h00);
		end
	end

	// ------------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------------
	// decode result stands one cycle per registered command
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_reg  <= '0;
			bank_reg <= '0;
			addr_reg <= '0;
		end else begin
			dec_reg.valid      <= take;
			dec_reg.cmd        <= take ? cmd_raw : sdcmd_pkg::cmd_nop;
			dec_reg.auto_close <= auto_cl;
			dec_reg.chop4      <= is_rw & chop4;
			dec_reg.zq_long    <= zq_long;
			dec_reg.pre_all    <= pre_all;
			bank_reg           <= take ? ba : '0;
			addr_reg           <= take ? addr : '0;
		end
	end

	// mode register write; only the low bank bits pick one of four
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mr_write_reg <= 1'b0;
			mr_sel_reg   <= '0;
			mr_op_reg    <= '0;
		end else begin
			mr_write_reg <= is_mrs;
			if (is_mrs) begin
				mr_sel_reg <= ba[`SDCMD_MR_SEL_W-1:0];
				mr_op_reg  <= addr;
			end
		end
	end

	// first long calibration after reset is the initial one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zq_done_reg <= 1'b0;
			zq_init_reg <= 1'b0;
		end else begin
			zq_init_reg <= zq_long & ~zq_done_reg;
			if (zq_long) begin
				zq_done_reg <= 1'b1;
			end
		end
	end

	// refresh enable follows the next state so it matches pstate_reg
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			refresh_en_reg <= 1'b0;
			busy_reg       <= 1'b0;
			idle_reg       <= 1'b0;
		end else begin
			refresh_en_reg <= (state_next == sdcmd_pkg::pst_normal) |
			                  (state_next == sdcmd_pkg::pst_self);
			busy_reg       <= is_rw | (burst_cnt_reg > 8'h01);
			idle_reg       <= in_norm & pins.cke & all_idle & ~take;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_pd_ignores;
		(pstate_reg != sdcmd_pkg::pst_normal) && !pins.cke |=> !dec_reg.valid && $stable(pstate_reg);
	endproperty
	a_pd_ignores: assert property (p_pd_ignores) else $error("command taken in power-down");

	property p_mrs_select;
		is_mrs |=> mr_write_reg && (mr_sel_reg == $past(ba[1:0])) && (mr_op_reg == $past(addr));
	endproperty
	a_mrs_select: assert property (p_mrs_select) else $error("mode register select wrong");

	property p_auto_close;
		is_rw |=> dec_reg.auto_close == $past(addr[10]) && dec_reg.chop4 == ($past(otf_en) && !$past(addr[12]));
	endproperty
	a_auto_close: assert property (p_auto_close) else $error("read/write options wrong");

	property p_nop_quiet;
		nop_des |=> !dec_reg.valid && !mr_write_reg;
	endproperty
	a_nop_quiet: assert property (p_nop_quiet) else $error("no-op registered a command");

	property p_sre;
		in_norm && cke_fall && !pins.cs_n && cmd_raw == sdcmd_pkg::cmd_ref && all_idle
			|=> pstate_reg == sdcmd_pkg::pst_self && refresh_en_reg;
	endproperty
	a_sre: assert property (p_sre) else $error("self refresh entry missed");

	property p_pde_active;
		pde_go && !no_open |=> pstate_reg == sdcmd_pkg::pst_act_pd;
	endproperty
	a_pde_active: assert property (p_pde_active) else $error("active power-down entry missed");

	property p_exit;
		exit_go |=> in_norm && (exit_cnt_reg == `SDCMD_TXP_CYC) && refresh_en_reg;
	endproperty
	a_exit: assert property (p_exit) else $error("power-down exit missed");

	property p_no_refresh_pd;
		pstate_reg inside {sdcmd_pkg::pst_act_pd, sdcmd_pkg::pst_pre_pd, sdcmd_pkg::pst_pd} |-> !refresh_en_reg;
	endproperty
	a_no_refresh_pd: assert property (p_no_refresh_pd) else $error("refresh enabled in power-down");

	property p_burst_runs;
		is_rw && !chop4 |=> busy_reg [*4];
	endproperty
	a_burst_runs: assert property (p_burst_runs) else $error("burst cut short");

	property p_idle;
		idle_reg |-> no_open && !burst_busy && (pstate_reg == sdcmd_pkg::pst_normal);
	endproperty
	a_idle: assert property (p_idle) else $error("idle with work pending");

	property p_zq_init;
		zq_long && !zq_done_reg |=> zq_init_reg && dec_reg.zq_long;
	endproperty
	a_zq_init: assert property (p_zq_init) else $error("initial calibration not flagged");
endmodule : sdcmd_decoder
`default_nettype wire

// *** sdcmd_ctrl_model.sv ***
// controller-side model that drives the command bus of the decoder
`timescale 1ns/100ps
`default_nettype none
module sdcmd_ctrl_model #(
	parameter int BA_W = 3,
	parameter int A_W  = 15
) (
	// clock
	input  wire logic                  clk,
	// command bus
	output var sdcmd_pkg::sdcmd_pins_s pins,
	output var logic [BA_W-1:0]        ba,
	output var logic [A_W-1:0]         addr
);
	// ------------------------------------------------------------------
	// bus starts deselected with clock enable low
	// ------------------------------------------------------------------
	initial begin
		pins = 6'h3C;
		ba   = '0;
		addr = '0;
	end

	// one command per call, launched on the falling edge, held over the sampling edge
	task automatic drive(input logic cs_n, input logic [2:0] rcw, input logic cke,
		input logic [BA_W-1:0] b, input logic [A_W-1:0] a);
		@(negedge clk);
		pins.odt  = ~pins.odt;
		pins.cke  = cke;
		pins.cs_n = cs_n;
		if (cs_n) begin
			// deselected: scramble the rest so stale values cannot pass for a command
			{pins.ras_n, pins.cas_n, pins.we_n} = ~{pins.ras_n, pins.cas_n, pins.we_n};
			ba   = ~ba;
			addr = ~addr;
		end else begin
			{pins.ras_n, pins.cas_n, pins.we_n} = rcw;
			ba   = b;
			addr = a;
		end
		@(posedge clk);
		#1;
	endtask : drive
endmodule : sdcmd_ctrl_model
`default_nettype wire

// *** sdcmd_tb.sv ***
// self-checking testbench of the command and clock-enable decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
	// ------------------------------------------------------------------
	// signals
	// ------------------------------------------------------------------
	logic                     clk;
	logic                     rst_n;
	logic                     otf_en;
	sdcmd_pkg::sdcmd_pins_s   pins;
	logic [2:0]               ba;
	logic [14:0]              addr;
	sdcmd_pkg::sdcmd_dec_s    dec_reg;
	logic [2:0]               bank_reg;
	logic [14:0]              addr_reg;
	logic                     mr_write_reg;
	logic [1:0]               mr_sel_reg;
	logic [14:0]              mr_op_reg;
	logic                     zq_init_reg;
	sdcmd_pkg::sdcmd_pstate_e pstate_reg;
	logic                     refresh_en_reg;
	logic                     busy_reg;
	logic                     idle_reg;
	logic [7:0]               open_reg;
	int                       n_fail;
	int                       samples_checked;

	sdcmd_ctrl_model #(.BA_W(3), .A_W(15)) i_sdcmd_ctrl_model (.clk(clk), .pins(pins), .ba(ba), .addr(addr));
	sdcmd_decoder #(.BA_W(3), .A_W(15)) i_sdcmd_decoder (.clk(clk), .rst_n(rst_n), .pins(pins), .ba(ba),
		.addr(addr), .otf_en(otf_en), .dec_reg(dec_reg), .bank_reg(bank_reg), .addr_reg(addr_reg),
		.mr_write_reg(mr_write_reg), .mr_sel_reg(mr_sel_reg), .mr_op_reg(mr_op_reg),
		.zq_init_reg(zq_init_reg), .pstate_reg(pstate_reg), .refresh_en_reg(refresh_en_reg),
		.busy_reg(busy_reg), .idle_reg(idle_reg), .open_reg(open_reg));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : check

	task automatic go(input logic cs, input logic [2:0] rcw, input logic ck, input logic [2:0] b,
		input logic [14:0] a);
		i_sdcmd_ctrl_model.drive(cs, rcw, ck, b, a);
	endtask : go

	// nops until idle; refresh and exit timers must run out in bounded time
	task automatic wait_idle();
		for (int k = 0; k < 200 && idle_reg !== 1'b1; k++) go(1'b0, 3'h7, 1'b1, 3'h0, 15'h0000);
		check(idle_reg, 1'b1);
	endtask : wait_idle

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	// every strobe pattern once, a10 high so each option bit is exercised
	task automatic t_decode();
		sdcmd_pkg::sdcmd_dec_s exp;
		sdcmd_pkg::sdcmd_cmd_e tbl [8];
		logic [14:0]           a;
		tbl = '{sdcmd_pkg::cmd_mrs, sdcmd_pkg::cmd_ref, sdcmd_pkg::cmd_pre, sdcmd_pkg::cmd_act,
			sdcmd_pkg::cmd_wr, sdcmd_pkg::cmd_rd, sdcmd_pkg::cmd_zq, sdcmd_pkg::cmd_nop};
		for (int i = 0; i < 8; i++) begin
			a = 15'h0400 | 15'(i);
			go(1'b0, 3'(i), 1'b1, 3'h2, a);
			exp = '{i != 7, tbl[i], i == 4 || i == 5, i == 4 || i == 5, i == 6, i == 2};
			check(dec_reg, exp);
			check(addr_reg, (i != 7) ? a : 15'h0000);
			check(bank_reg, (i != 7) ? 3'h2 : 3'h0);
			check(mr_write_reg, i == 0);
			check(zq_init_reg, i == 6);
			if (i == 0) check({mr_sel_reg, mr_op_reg}, {2'h2, a});
		end
		exp = '0;
		exp.cmd = sdcmd_pkg::cmd_nop;
		go(1'b1, 3'h0, 1'b1, 3'h0, 15'h0000);
		check(dec_reg, exp);
		go(1'b0, 3'h6, 1'b1, 3'h0, 15'h0400);
		check({zq_init_reg, dec_reg.zq_long}, 2'h1);
		go(1'b0, 3'h6, 1'b1, 3'h0, 15'h7BFF);
		check(dec_reg.zq_long, 1'b0);
		$display("test decode done");
	endtask : t_decode

	// burst length choice and bursts that nop and deselect cannot cut short
	task automatic t_burst();
		go(1'b0, 3'h3, 1'b1, 3'h1, 15'h0000);
		check(idle_reg, 1'b0);
		go(1'b0, 3'h5, 1'b1, 3'h1, 15'h1000);
		check({dec_reg.chop4, dec_reg.auto_close, busy_reg}, 3'h1);
		go(1'b1, 3'h0, 1'b1, 3'h0, 15'h0000);
		go(1'b0, 3'h7, 1'b1, 3'h0, 15'h0000);
		check(busy_reg, 1'b1);
		@(negedge clk) otf_en = 1'b0;
		go(1'b0, 3'h4, 1'b1, 3'h1, 15'h0000);
		check({dec_reg.cmd, dec_reg.chop4, open_reg}, {sdcmd_pkg::cmd_wr, 1'b0, 8'h02});
		// a nop first: a write left on the bus over the idle edge would be taken twice
		go(1'b0, 3'h7, 1'b1, 3'h0, 15'h0000);
		check(busy_reg, 1'b1);
		@(negedge clk) otf_en = 1'b1;
		$display("test burst done");
	endtask : t_burst

	// single and all-bank close
	task automatic t_bank();
		go(1'b0, 3'h2, 1'b1, 3'h0, 15'h0400);
		check(open_reg, 8'h00);
		go(1'b0, 3'h3, 1'b1, 3'h3, 15'h0000);
		go(1'b0, 3'h3, 1'b1, 3'h5, 15'h0000);
		check(open_reg, 8'h28);
		go(1'b0, 3'h2, 1'b1, 3'h3, 15'h0000);
		check(open_reg, 8'h20);
		go(1'b0, 3'h2, 1'b1, 3'h3, 15'h0400);
		check(open_reg, 8'h00);
		$display("test bank done");
	endtask : t_bank

	// every clock-enable transition, commands ignored while it is low
	task automatic t_power();
		go(1'b0, 3'h3, 1'b1, 3'h6, 15'h0000);
		go(1'b0, 3'h7, 1'b0, 3'h0, 15'h0000);
		check({pstate_reg, refresh_en_reg}, {sdcmd_pkg::pst_act_pd, 1'b0});
		go(1'b0, 3'h5, 1'b0, 3'h6, 15'h0000);
		check({pstate_reg, dec_reg.valid}, {sdcmd_pkg::pst_act_pd, 1'b0});
		go(1'b1, 3'h0, 1'b1, 3'h0, 15'h0000);
		check(pstate_reg, sdcmd_pkg::pst_normal);
		go(1'b0, 3'h2, 1'b1, 3'h0, 15'h0400);
		wait_idle();
		go(1'b0, 3'h7, 1'b0, 3'h0, 15'h0000);
		check(pstate_reg, sdcmd_pkg::pst_pre_pd);
		go(1'b1, 3'h0, 1'b0, 3'h0, 15'h0000);
		go(1'b1, 3'h0, 1'b1, 3'h0, 15'h0000);
		check(pstate_reg, sdcmd_pkg::pst_normal);
		wait_idle();
		go(1'b0, 3'h3, 1'b1, 3'h0, 15'h0000);
		go(1'b0, 3'h5, 1'b1, 3'h0, 15'h1400);
		go(1'b0, 3'h7, 1'b0, 3'h0, 15'h0000);
		check(pstate_reg, sdcmd_pkg::pst_pd);
		go(1'b0, 3'h7, 1'b1, 3'h0, 15'h0000);
		wait_idle();
		go(1'b0, 3'h1, 1'b0, 3'h0, 15'h0000);
		check({pstate_reg, refresh_en_reg, dec_reg.valid}, {sdcmd_pkg::pst_self, 2'h2});
		go(1'b0, 3'h1, 1'b0, 3'h0, 15'h0000);
		check(pstate_reg, sdcmd_pkg::pst_self);
		go(1'b1, 3'h0, 1'b1, 3'h0, 15'h0000);
		check(pstate_reg, sdcmd_pkg::pst_normal);
		$display("test power done");
	endtask : t_power

	// ------------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------------
	initial begin
		n_fail          = 0;
		samples_checked = 0;
		otf_en          = 1'b1;
		rst_n           = 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		go(1'b0, 3'h7, 1'b1, 3'h0, 15'h0000);
		go(1'b0, 3'h7, 1'b1, 3'h0, 15'h0000);
		t_decode();
		t_burst();
		t_bank();
		t_power();
		finish_test();
	end

	// the whole run needs well under a thousand cycles
	initial begin
		#200000;
		n_fail++;
		$display("FAIL at %0t: got %0h expected %0h", $time, 1'b0, 1'b1);
		finish_test();
	end
endmodule : testbench
`default_nettype wire
